/* File: rtl/flash_susp_pkg.sv */
// How it works
// (RL1) Mode zero data erase: acknowledge sets suspend request
// (RL2) Erase halts after suspend latency, then suspended
// (RL3) Without irq enable, handler writes request bit
// (RL4) While suspended, all other blocks stay accessible
// (RL5) Writing request zero resumes the suspended erase
// (RL6) Mode zero data flash: interrupts run concurrently
// (RL7) Program ROM erase: interrupt vectors held in RAM
// (RL8) No trap or break instructions during ROM rewrite
// (RL9) Mode one ROM: suspend before handler runs
// (RL10) Mode one ROM, no suspend: interrupts wait
// (RL11) Suspended state readable by software
package flash_susp_pkg;

    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int CLK_PERIOD_NS      = 8;
    localparam int SUSPEND_LATENCY_NS = 1000;
    localparam int ERASE_TIME_NS      = 20000;
    localparam int PROG_TIME_NS       = 2000;
    localparam int CNT_W              = 12;
    // Least times round up to whole cycles
    localparam logic [CNT_W-1:0] SUSPEND_LATENCY_CYC = CNT_W'(
        (SUSPEND_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] ERASE_CYC = CNT_W'(
        (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] PROG_CYC = CNT_W'(
        (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] CMD_OFS    = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;

    // Control register fields
    localparam int ERASE_SUSPEND_REQUEST_BIT = 0;
    localparam int IRQ_SUSPEND_ENABLE_BIT    = 1;
    localparam int SUSPEND_ALLOW_BIT         = 2;
    localparam int REWRITE_MODE_ONE_BIT      = 3;
    localparam int TARGET_ROM_BIT            = 4;
    localparam logic [4:0] CTRL_RESET        = 5'h00;

    // Command register fields
    localparam int CMD_ERASE_BIT = 0;
    localparam int CMD_PROG_BIT  = 1;
    localparam int BLOCK_LSB     = 8;
    localparam int BLOCK_W       = 4;

    // Status register fields
    localparam int ST_BUSY_BIT      = 0;
    localparam int ST_ERASE_BIT     = 1;
    localparam int ST_PROG_BIT      = 2;
    localparam int ST_SUS_WAIT_BIT  = 3;
    localparam int ST_SUSPENDED_BIT = 4;
    localparam int ST_IRQ_HOLD_BIT  = 5;

    // ****************************************
    // Sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_ERASE     = 3'b001,
        ST_PROG      = 3'b010,
        ST_SUS_WAIT  = 3'b011,
        ST_SUSPENDED = 3'b100
    } seq_state_t;

endpackage : flash_susp_pkg

/* File: rtl/cycle_timer.sv */
`timescale 1ns/100ps
module cycle_timer
    import flash_susp_pkg::*;
(
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Control
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] load_value,
    input  wire logic             run,
    // Status
    output logic                  done
);

    logic [CNT_W-1:0] count;

    assign done = (count == '0);

    // Down counter, holds while run is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (load) begin
            count <= load_value;
        end else if (run && !done) begin
            count <= count - 1'b1;
        end
    end

endmodule : cycle_timer

/* File: rtl/flash_erase_suspend_control.sv */
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module flash_erase_suspend_control
    import flash_susp_pkg::*;
(
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Interrupt controller side
    input  wire logic                 irq_pending,
    input  wire logic                 irq_ack,
    output logic                      irq_hold,
    // CPU flash access check
    input  wire logic                 acc_valid,
    input  wire logic [BLOCK_W-1:0]   acc_block,
    output logic                      acc_allow,
    // Sequencer state
    output logic                      flash_busy,
    output logic                      flash_suspended
);
    import flash_susp_pkg::*;

    // ****************************************
    // Storage
    // ****************************************
    seq_state_t         state;
    seq_state_t         next_state;
    logic               erase_suspend_request;
    logic               irq_suspend_enable;
    logic               suspend_allow;
    logic               rewrite_mode_one;
    logic               target_rom;
    logic [BLOCK_W-1:0] op_block;

    // ****************************************
    // APB decode
    // ****************************************
    wire access    = psel && penable && !pready;
    wire wr        = access && pwrite;
    wire hit_ctrl  = (paddr == CTRL_OFS);
    wire hit_cmd   = (paddr == CMD_OFS);
    wire hit_stat  = (paddr == STATUS_OFS);
    wire unmapped  = !(hit_ctrl || hit_cmd || hit_stat);
    wire wr_ctrl   = wr && hit_ctrl;
    wire wr_cmd    = wr && hit_cmd;

    // ****************************************
    // Sequencer conditions
    // ****************************************
    wire is_idle      = (state == ST_IDLE);
    wire is_erase     = (state == ST_ERASE);
    wire is_prog      = (state == ST_PROG);
    wire is_sus_wait  = (state == ST_SUS_WAIT);
    wire is_suspended = (state == ST_SUSPENDED);
    wire start_erase  = wr_cmd && is_idle && pwdata[CMD_ERASE_BIT];
    wire start_prog   = wr_cmd && is_idle && !pwdata[CMD_ERASE_BIT]
                        && pwdata[CMD_PROG_BIT];
    wire mode_zero_df = !rewrite_mode_one && !target_rom;
    wire mode_one_rom = rewrite_mode_one && target_rom;
    wire susp_path    = suspend_allow && irq_suspend_enable;

    // Hardware requests a suspend from an interrupt
    wire hw_susp_set  = is_erase && susp_path
                        && ((mode_zero_df && irq_ack)         // RL1
                        || (mode_one_rom && irq_pending));    // RL9

    // Interrupts wait while mode one ROM is rewritten; taken from the
    // next state so hold drops together with suspend entry or the end
    wire next_running  = (next_state != ST_IDLE)
                         && (next_state != ST_SUSPENDED);
    wire next_irq_hold = mode_one_rom && next_running
                         && irq_pending;                      // RL9 RL10

    // Software write of the request bit; hardware set wins
    wire sw_req_val   = pwdata[ERASE_SUSPEND_REQUEST_BIT];
    wire next_request = hw_susp_set ? 1'b1                   // RL1
                      : wr_ctrl     ? sw_req_val             // RL3 RL5
                      : erase_suspend_request;

    // Timers
    logic op_done;
    logic lat_done;
    wire  op_load  = start_erase || start_prog;
    wire  [CNT_W-1:0] op_len = start_erase ? ERASE_CYC : PROG_CYC;
    wire  lat_load = is_erase && erase_suspend_request;

    // Access gate: all blocks locked while running, only the interrupted block while suspended
    wire next_acc_allow = acc_valid && (is_idle
                          || (is_suspended
                              && acc_block != op_block));     // RL4

    // ****************************************
    // Read mux
    // ****************************************
    wire [31:0] ctrl_rd = {27'h000_0000, target_rom, rewrite_mode_one,
                           suspend_allow, irq_suspend_enable,
                           erase_suspend_request};
    wire [31:0] cmd_rd  = {20'h0_0000, op_block, 8'h00};
    wire [31:0] stat_rd = {16'h0000, op_block, 6'h00,
                           irq_hold, is_suspended,
                           is_sus_wait, is_prog,
                           is_erase, !is_idle};              // RL11
    wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd
                        : hit_cmd  ? cmd_rd
                        : hit_stat ? stat_rd
                        : 32'h0000_0000;

    // ****************************************
    // Timers
    // ****************************************
    // Operation length, frozen while suspending or suspended
    cycle_timer u_op_timer (
        .pclk       (pclk),
        .presetn    (presetn),
        .load       (op_load),
        .load_value (op_len),
        .run        (is_erase || is_prog),
        .done       (op_done)
    );

    // Suspend latency after the request is seen
    cycle_timer u_lat_timer (
        .pclk       (pclk),
        .presetn    (presetn),
        .load       (lat_load),
        .load_value (SUSPEND_LATENCY_CYC),
        .run        (is_sus_wait),
        .done       (lat_done)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_erase) begin
                    next_state = ST_ERASE;
                end else if (start_prog) begin
                    next_state = ST_PROG;
                end
            end
            ST_ERASE: begin
                // Concurrent handling: erase just carries on
                if (erase_suspend_request) begin
                    next_state = ST_SUS_WAIT;                 // RL2
                end else if (op_done) begin
                    next_state = ST_IDLE;                     // RL6
                end
            end
            ST_PROG: begin
                if (op_done) begin
                    next_state = ST_IDLE;                     // RL6 RL10
                end
            end
            ST_SUS_WAIT: begin
                if (lat_done) begin
                    next_state = ST_SUSPENDED;                // RL2
                end
            end
            ST_SUSPENDED: begin
                if (!erase_suspend_request) begin
                    next_state = ST_ERASE;                    // RL5
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // State and control registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Control bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {target_rom, rewrite_mode_one, suspend_allow,
             irq_suspend_enable} <= CTRL_RESET[4:1];
            erase_suspend_request <= CTRL_RESET[0];
        end else begin
            erase_suspend_request <= next_request;
            if (wr_ctrl) begin
                irq_suspend_enable <= pwdata[IRQ_SUSPEND_ENABLE_BIT];
                suspend_allow      <= pwdata[SUSPEND_ALLOW_BIT];
                rewrite_mode_one   <= pwdata[REWRITE_MODE_ONE_BIT];
                target_rom         <= pwdata[TARGET_ROM_BIT];
            end
        end
    end

    // Block under operation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_block <= '0;
        end else if (op_load) begin
            op_block <= pwdata[BLOCK_LSB +: BLOCK_W];
        end
    end

    // ****************************************
    // APB answer, one wait state
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= access;
            pslverr <= access && unmapped;
            prdata  <= (access && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // ****************************************
    // Registered outputs
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_hold        <= 1'b0;
            acc_allow       <= 1'b0;
            flash_busy      <= 1'b0;
            flash_suspended <= 1'b0;
        end else begin
            irq_hold        <= next_irq_hold;
            acc_allow       <= next_acc_allow;
            flash_busy      <= (next_state != ST_IDLE);
            flash_suspended <= (next_state == ST_SUSPENDED);  // RL11
        end
    end

endmodule : flash_erase_suspend_control

/* File: bench/flash_susp_chk.sv */
`timescale 1ns/100ps
// ****************
// Port checker
// ****************
module flash_susp_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    // Interrupt and access side
    input wire logic irq_pending,
    input wire logic irq_ack,
    input wire logic irq_hold,
    input wire logic acc_valid,
    input wire logic acc_allow,
    // Sequencer state
    input wire logic flash_busy,
    input wire logic flash_suspended
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] lat_cnt;
    // Cycles since the last suspend trigger, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            lat_cnt <= 8'h00;
        else if ((psel && penable && pwrite) || irq_ack || $rose(irq_pending))
            lat_cnt <= 8'h00;
        else if (lat_cnt != 8'hff)
            lat_cnt <= lat_cnt + 8'h01;
    end
    AST_LATENCY: assert property (
        $rose(flash_suspended) |-> lat_cnt >= 8'd124)
        else $error("suspend came before the latency");
    AST_SUSP_BUSY: assert property (flash_suspended |-> flash_busy)
        else $error("suspended while not busy");
    AST_RESUME: assert property (
        $fell(flash_suspended) |-> $past(psel && penable && pwrite, 1)
        || $past(psel && penable && pwrite, 2))
        else $error("resume without a register write");
    AST_ACC_IDLE: assert property (
        acc_valid && !flash_busy |=> acc_allow)
        else $error("access refused while idle");
    AST_ACC_RUN: assert property (
        acc_valid && flash_busy && !flash_suspended |=> !acc_allow)
        else $error("access allowed while running");
    AST_HOLD: assert property (
        irq_hold |-> flash_busy && !flash_suspended)
        else $error("interrupt hold outside a running operation");
    AST_READY: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("ready not one pulse after one wait");
    AST_ERR: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule : flash_susp_chk

bind flash_erase_suspend_control flash_susp_chk u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .irq_pending(irq_pending),
    .irq_ack(irq_ack), .irq_hold(irq_hold), .acc_valid(acc_valid),
    .acc_allow(acc_allow), .flash_busy(flash_busy),
    .flash_suspended(flash_suspended));

/* File: bench/cpu_irq_model.sv */
`timescale 1ns/100ps
// ****************
// Interrupt controller and CPU
// ****************
module cpu_irq_model (
    // Clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // Stimulus
    input wire logic       raise,
    input wire logic [3:0] ack_delay,
    // Flash side
    input wire logic       irq_hold,
    output logic           irq_pending,
    output logic           irq_ack
);
    logic [3:0] wait_cnt;
    // Handler uses RAM vectors, never trap or break instructions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_pending <= 1'b0;
            irq_ack     <= 1'b0;
            wait_cnt    <= 4'h0;
        end else begin
            irq_ack <= 1'b0;
            if (raise) begin
                irq_pending <= 1'b1;
                // Arbitration needs a cycle, so a fresh hold is seen
                wait_cnt    <= (ack_delay == 4'h0) ? 4'h1 : ack_delay;
            end else if (irq_pending && !irq_hold) begin
                if (wait_cnt != 4'h0)
                    wait_cnt <= wait_cnt - 4'h1;
                else begin
                    irq_ack     <= 1'b1;
                    irq_pending <= 1'b0;
                end
            end
        end
    end
endmodule : cpu_irq_model

/* File: bench/flash_erase_suspend_control_test.sv */
`timescale 1ns/100ps
module flash_erase_suspend_control_test;
    import flash_susp_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, raise;
    logic irq_pending, irq_ack, irq_hold, acc_valid, acc_allow, al;
    logic flash_busy, flash_suspended;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [BLOCK_W-1:0] acc_block, blk;
    logic [3:0] ack_delay;
    logic [4:0] ctrl;
    int bad_count, n_checks, n, a0, m;
    int n_ack = 0;
    always #4 pclk = ~pclk;
    always @(posedge pclk) if (irq_ack === 1'b1) n_ack <= n_ack + 1;
    flash_erase_suspend_control u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_pending(irq_pending), .irq_ack(irq_ack),
        .irq_hold(irq_hold), .acc_valid(acc_valid), .acc_block(acc_block),
        .acc_allow(acc_allow), .flash_busy(flash_busy),
        .flash_suspended(flash_suspended));
    cpu_irq_model u_cpu (.pclk(pclk), .presetn(presetn), .raise(raise),
        .ack_delay(ack_delay), .irq_hold(irq_hold),
        .irq_pending(irq_pending), .irq_ack(irq_ack));
    // ****************
    // Tasks
    // ****************
    task automatic chk(input string nm, input logic [31:0] ex, got);
        n_checks++;
        if (got !== ex) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int t;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (pready !== 1'b1) bad_count++;
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_state(input logic susp);
        logic seen;
        n = 0;
        seen = susp ? flash_suspended : flash_busy;
        while (n < 6000 && seen !== susp) begin
            @(posedge pclk);
            n++;
            seen = susp ? flash_suspended : flash_busy;
        end
        if (seen !== susp) bad_count++;
    endtask : wait_state
    task automatic acc(input logic [BLOCK_W-1:0] b);
        @(posedge pclk);
        {acc_valid, acc_block} <= {1'b1, b};
        repeat (2) @(posedge pclk);
        al = acc_allow;
        acc_valid <= 1'b0;
    endtask : acc
    task automatic conclude;
        if (bad_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    // ****************
    // Sequence
    // ****************
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {raise, acc_valid, acc_block, ack_delay} = '0;
        void'($urandom(24));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, CTRL_OFS, 0); chk("ctrl_reset", 0, q);
        apb(0, STATUS_OFS, 0); chk("status_reset", 0, q);
        apb(0, 8'h0c, 0); chk("unmapped_err", 1, e);
        // Mode zero auto, mode zero software, mode one program ROM
        for (m = 0; m < 3; m++) begin
            blk = BLOCK_W'($urandom_range(0, 15));
            ack_delay <= 4'($urandom_range(0, 15));
            ctrl = (m == 2) ? 5'h1e : (m == 1) ? 5'h04 : 5'h06;
            apb(1, CTRL_OFS, 32'(ctrl));
            apb(1, CMD_OFS, (32'(blk) << BLOCK_LSB) | 32'h0000_0001);
            a0 = n_ack;
            @(posedge pclk) raise <= 1'b1;
            @(posedge pclk) raise <= 1'b0;
            if (m == 1) begin
                repeat (200) @(posedge pclk);
                chk("concurrent", 0, flash_suspended);
                chk("ack_running", a0 + 1, n_ack);
                apb(1, CTRL_OFS, 32'(ctrl) | 32'h0000_0001);
            end
            wait_state(1);
            chk("latency", 1, n >= 120 && n <= 160);
            if (m == 2) chk("ack_after", a0, n_ack);
            chk("hold_low", 0, irq_hold);
            apb(0, CTRL_OFS, 0); chk("req_bit", 1, q[0]);
            apb(0, STATUS_OFS, 0); chk("susp_bit", 1, q[4]);
            chk("susp_block", blk, q[15:12]);
            acc(blk ^ 4'h1); chk("other_block", 1, al);
            acc(blk); chk("own_block", 0, al);
            apb(1, CTRL_OFS, 32'(ctrl));
            wait_state(0);
            chk("resumed", 1, n > 1000 && n < 3000);
        end
        // Mode one program ROM, suspend off: interrupt waits
        apb(1, CTRL_OFS, 32'h0000_0018);
        apb(1, CMD_OFS, 32'h0000_0001);
        a0 = n_ack;
        @(posedge pclk) raise <= 1'b1;
        @(posedge pclk) raise <= 1'b0;
        repeat (100) @(posedge pclk);
        chk("hold_high", 1, irq_hold);
        chk("ack_held", a0, n_ack);
        wait_state(0);
        repeat (20) @(posedge pclk);
        chk("ack_done", a0 + 1, n_ack);
        // Mode zero data flash program: interrupt runs alongside
        apb(1, CTRL_OFS, 32'h0000_0006);
        apb(1, CMD_OFS, 32'h0000_0002);
        apb(0, STATUS_OFS, 0); chk("prog_bit", 1, q[2]);
        a0 = n_ack;
        @(posedge pclk) raise <= 1'b1;
        @(posedge pclk) raise <= 1'b0;
        repeat (30) @(posedge pclk);
        chk("prog_ack", a0 + 1, n_ack);
        chk("prog_busy", 1, flash_busy);
        chk("prog_no_susp", 0, flash_suspended);
        wait_state(0);
        chk("prog_len", 1, n > 150 && n < 250);
        conclude();
    end
    // Watchdog
    initial begin
        repeat (40000) @(posedge pclk);
        bad_count++;
        conclude();
    end
endmodule : flash_erase_suspend_control_test
